// ---- verilog/tsa_pkg.sv ----
// Constants and register map of the superframe alignment block.
// Functional notes
// - A timeslot is two data clocks; slot zero follows the frame sync.
// - Any assigner enable set overrides the 8/10-bit frame format.
// - Markers run only when enabled in native short or long format.
// - Transmit marker flags the frame sent first in line frame one.
// - NT marker is output; LT marker is input unless output enabled.
// - LT without marker input picks its own transmit superframe start.
// - Receive marker is an output flagging the first received frame.
// - Alignment indications repeat every 96 frames of 125 us.
// - Short format markers pulse one data clock after frame sync.
// - Long format markers stay high for the whole frame sync.
// - GCI format signals alignment on its frame sync; marker ignored.
// - LT GCI slave without one-clock sync aligns on its own.
// - GCI master outputs a one-clock frame sync every 96 frames.
// - NT GCI slave ignores alignment carried on the frame sync.
// - NT transmits its sync word 60 bauds, 750 us, after reception.
// - All ones sent until payload pass bit set after act bit seen.
// - Verified mode enables transparency automatically on act bit.
// - FIFO latency stays fixed within one activation.
// - Non-transparent loopback blocks data and sends all-ones idle.
package tsa_pkg;
  localparam logic [7:0] ADDR_OVL6 = 8'h00;
  localparam logic [7:0] ADDR_OVL8 = 8'h04;
  localparam logic [7:0] ADDR_NIB2 = 8'h08;
  localparam logic [7:0] ADDR_BYTE9 = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_SLOT = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  // Overlay register 6 and 8, nibble 2 and byte 9 bit positions.
  localparam int OVL6_TSA_B1 = 7;
  localparam int OVL6_TSA_B2 = 6;
  localparam int OVL6_TSA_D = 5;
  localparam int OVL6_GCI = 3;
  localparam int OVL8_MK_EN = 1;
  localparam int OVL8_MK_OUT = 5;
  localparam int NIB2_PASS = 0;
  localparam int BYTE9_VER_HI = 5;
  localparam int BYTE9_VER_LO = 4;
  localparam logic [1:0] VERIFIED_MODE = 2'h1;
  // Control register bits.
  localparam int CTRL_LT = 0;
  localparam int CTRL_GCI_MASTER = 1;
  localparam int CTRL_LONG = 2;
  localparam int CTRL_FMT10 = 3;
  localparam int CTRL_LOOP = 4;
  localparam int CTRL_LOOP_TRANSP = 5;
  localparam int CTRL_W = 6;
  localparam logic [7:0] OVL6_RST = 8'h00;
  localparam logic [7:0] OVL8_RST = 8'h00;
  localparam logic [3:0] NIB2_RST = 4'h0;
  localparam logic [7:0] BYTE9_RST = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [15:0] SLOT_RST = 16'h0000;
  // Frame timing.
  localparam logic [6:0] SF_FRAMES = 7'h60;
  localparam int FRAME_US = 125;
  localparam logic [9:0] CNT_PRE = 10'h3FF;
  localparam logic [9:0] B_CLKS = 10'h008;
  localparam logic [9:0] FMT10_START = 10'h001;
  localparam logic [9:0] GCI_FRAME_DCLS = 10'h200;
  localparam logic [9:0] GCI_SYNC_DCLS = 10'h002;
  localparam int CLK_MHZ = 125;
  localparam int TURN_US = 750;
  localparam int TURN_CYCLES = TURN_US * CLK_MHZ;
  localparam logic [17:0] IDLE_ONES = 18'h3FFFF;
endpackage : tsa_pkg

// ---- verilog/tsa_superframe_align.sv ----
// Superframe alignment, channel placement and idle control of the TDM port.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tsa_superframe_align
  import tsa_pkg::*;
#(
  parameter int TURN_CNT = TURN_CYCLES
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic port_data_clock_i,
  input wire logic tx_frame_sync_i,
  input wire logic rx_frame_sync_i,
  input wire logic gci_frame_sync_i,
  output logic gci_frame_sync_o,
  output logic gci_frame_sync_oe_o,
  input wire logic tx_superframe_marker_i,
  output logic tx_superframe_marker_o,
  output logic tx_superframe_marker_oe_o,
  output logic rx_superframe_marker_o,
  output logic tx_b1_window_o,
  output logic rx_b1_window_o,
  input wire logic activation_i,
  input wire logic m4_act_i,
  input wire logic line_rx_sf_start_i,
  output logic line_tx_sf_start_o,
  input wire logic [17:0] tx_bd_i,
  output logic [17:0] line_tx_bd_o,
  input wire logic [17:0] line_rx_bd_i,
  output logic [17:0] rx_bd_o,
  output logic transparent_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Synchroniser lanes: 0 data clock, 1 tx sync, 2 rx sync, 3 gci sync,
  // 4 marker input.
  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] sync;
    logic [4:0] prev;
    logic [9:0] tx_cnt;
    logic [9:0] rx_cnt;
    logic [6:0] tx_idx;
    logic [6:0] rx_idx;
    logic [9:0] gci_cnt;
    logic [1:0] fsc_w;
    logic rx_pend;
    logic rx_lock;
    logic tx_pend;
    logic tx_lock;
    logic [16:0] turn_cnt;
    logic turn_run;
    logic transp;
    logic act_p;
    logic [7:0] ovl6;
    logic [7:0] ovl8;
    logic [3:0] nib2;
    logic [7:0] byte9;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] slot;
    logic [31:0] prdata;
    logic slverr;
    logic tx_mk;
    logic rx_mk;
    logic fsc_out;
    logic line_sf;
    logic tx_win;
    logic rx_win;
    logic [17:0] line_tx;
    logic [17:0] rx_bd;
  } tsa_state_t;

  tsa_state_t s_q;
  tsa_state_t s_d;

  logic dcl_rise;
  logic dcl_fall;
  logic gci_mode;
  logic gci_master;
  logic lt_mode;
  logic tsa_on;
  logic native_mk;
  logic mk_input;
  logic tx_fs;
  logic rx_fs;
  logic tx_start;
  logic rx_start;
  logic fsc_fall;
  logic [9:0] tx_b1_start;
  logic [9:0] rx_b1_start;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic [31:0] rd_val;
  logic [6:0] tx_next;
  logic [6:0] rx_next;
  logic passing;

  assign dcl_rise = s_q.sync[0] & ~s_q.prev[0];
  assign dcl_fall = ~s_q.sync[0] & s_q.prev[0];
  assign gci_mode = s_q.ovl6[OVL6_GCI];
  assign gci_master = s_q.ctrl[CTRL_GCI_MASTER];
  assign lt_mode = s_q.ctrl[CTRL_LT];
  assign tsa_on = s_q.ovl6[OVL6_TSA_B1] | s_q.ovl6[OVL6_TSA_B2]
                  | s_q.ovl6[OVL6_TSA_D];
  assign native_mk = s_q.ovl8[OVL8_MK_EN] & ~gci_mode;
  assign mk_input = native_mk & lt_mode & ~s_q.ovl8[OVL8_MK_OUT];
  // In GCI format both directions share one frame sync, our own as master.
  assign tx_fs = gci_mode ? (gci_master ? s_q.fsc_out : s_q.sync[3])
                          : s_q.sync[1];
  assign rx_fs = gci_mode ? (gci_master ? s_q.fsc_out : s_q.sync[3])
                          : s_q.sync[2];
  assign tx_start = dcl_rise & tx_fs & (s_q.tx_cnt != CNT_PRE);
  assign rx_start = dcl_rise & rx_fs & (s_q.rx_cnt != CNT_PRE);
  assign fsc_fall = dcl_rise & ~s_q.sync[3] & (s_q.fsc_w != 2'h0);
  assign tx_next = (s_q.tx_idx == SF_FRAMES - 7'h01) ? 7'h00
                                                     : s_q.tx_idx + 7'h01;
  assign rx_next = (s_q.rx_idx == SF_FRAMES - 7'h01) ? 7'h00
                                                     : s_q.rx_idx + 7'h01;
  assign tx_b1_start = tsa_on ? {1'b0, s_q.slot[7:0], 1'b0}
                     : (s_q.ctrl[CTRL_FMT10] ? FMT10_START : 10'h000);
  assign rx_b1_start = tsa_on ? {1'b0, s_q.slot[15:8], 1'b0}
                     : (s_q.ctrl[CTRL_FMT10] ? FMT10_START : 10'h000);
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i;
  assign passing = s_q.transp;

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr_i)
      ADDR_OVL6: rd_val = {24'h000000, s_q.ovl6};
      ADDR_OVL8: rd_val = {24'h000000, s_q.ovl8};
      ADDR_NIB2: rd_val = {28'h0000000, s_q.nib2};
      ADDR_BYTE9: rd_val = {24'h000000, s_q.byte9};
      ADDR_CTRL: rd_val = {26'h0000000, s_q.ctrl};
      ADDR_SLOT: rd_val = {16'h0000, s_q.slot};
      ADDR_STAT: rd_val = {14'h0000, s_q.transp, s_q.tx_lock, s_q.rx_lock,
                           s_q.tx_idx, 1'b0, s_q.rx_idx};
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.meta = {tx_superframe_marker_i, gci_frame_sync_i, rx_frame_sync_i,
                tx_frame_sync_i, port_data_clock_i};
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.act_p = activation_i;
    s_d.line_sf = 1'b0;

    if (rd_setup) begin
      s_d.prdata = rd_val;
      s_d.slverr = ~mapped;
    end
    if (wr_acc & mapped) begin
      unique case (paddr_i)
        ADDR_OVL6: s_d.ovl6 = pwdata_i[7:0];
        ADDR_OVL8: s_d.ovl8 = pwdata_i[7:0];
        ADDR_NIB2: s_d.nib2 = pwdata_i[3:0];
        ADDR_BYTE9: s_d.byte9 = pwdata_i[7:0];
        ADDR_CTRL: s_d.ctrl = pwdata_i[CTRL_W-1:0];
        ADDR_SLOT: s_d.slot = pwdata_i[15:0];
        default: s_d.slverr = s_q.slverr;
      endcase
    end

    if (dcl_rise) begin
      s_d.tx_cnt = tx_fs ? CNT_PRE : s_q.tx_cnt + 10'h001;
      s_d.rx_cnt = rx_fs ? CNT_PRE : s_q.rx_cnt + 10'h001;
    end

    if (tx_start) begin
      s_d.tx_idx = s_q.tx_pend ? 7'h00 : tx_next;
      s_d.tx_pend = 1'b0;
      s_d.line_sf = s_q.tx_pend | (tx_next == 7'h00);
    end
    if (rx_start) begin
      s_d.rx_idx = s_q.rx_pend ? 7'h00 : rx_next;
      s_d.rx_pend = 1'b0;
    end

    if (line_rx_sf_start_i & ~s_q.rx_lock) begin
      s_d.rx_pend = 1'b1;
      s_d.rx_lock = 1'b1;
    end
    if (line_rx_sf_start_i & ~lt_mode & ~s_q.tx_lock) begin
      s_d.turn_run = 1'b1;
      s_d.turn_cnt = 17'(TURN_CNT - 1);
      s_d.tx_lock = 1'b1;
    end else if (s_q.turn_run) begin
      if (s_q.turn_cnt == 17'h00000) begin
        s_d.turn_run = 1'b0;
        s_d.tx_pend = 1'b1;
      end else begin
        s_d.turn_cnt = s_q.turn_cnt - 17'h00001;
      end
    end

    // sample marker input on falling edge
    if (mk_input & dcl_fall & (s_q.tx_cnt == 10'h000)
        & s_q.sync[4]) begin
      s_d.tx_idx = 7'h00;
    end

    if (dcl_rise) begin
      s_d.fsc_w = s_q.sync[3] ? ((s_q.fsc_w == 2'h3) ? s_q.fsc_w
                                 : s_q.fsc_w + 2'h1) : 2'h0;
    end
    if (gci_mode & ~gci_master & lt_mode & fsc_fall
        & (s_q.fsc_w == 2'h1)) begin
      s_d.tx_idx = 7'h00;
    end

    if (dcl_rise) begin
      s_d.gci_cnt = (s_q.gci_cnt == GCI_FRAME_DCLS - 10'h001) ? 10'h000
                    : s_q.gci_cnt + 10'h001;
      s_d.fsc_out = (s_d.gci_cnt == 10'h000) |
                    ((s_d.gci_cnt < GCI_SYNC_DCLS) & (rx_next != 7'h00));
    end

    s_d.tx_mk = native_mk & ~mk_input & (s_q.ctrl[CTRL_LONG]
      ? s_q.sync[1] & ((s_q.tx_cnt == CNT_PRE) ? (s_q.tx_idx == 7'h00)
                       : (s_q.tx_pend | (tx_next == 7'h00)))
      : (s_q.tx_idx == 7'h00) & (s_q.tx_cnt == 10'h000));
    s_d.rx_mk = native_mk & (s_q.ctrl[CTRL_LONG]
      ? s_q.sync[2] & ((s_q.rx_cnt == CNT_PRE) ? (s_q.rx_idx == 7'h00)
                       : (s_q.rx_pend | (rx_next == 7'h00)))
      : (s_q.rx_idx == 7'h00) & (s_q.rx_cnt == 10'h000));

    s_d.tx_win = (s_q.tx_cnt >= tx_b1_start) &
                 (s_q.tx_cnt < tx_b1_start + B_CLKS);
    s_d.rx_win = (s_q.rx_cnt >= rx_b1_start) &
                 (s_q.rx_cnt < rx_b1_start + B_CLKS);

    // pass bit after act; verified mode
    if (m4_act_i & (s_q.nib2[NIB2_PASS] |
        ({s_q.byte9[BYTE9_VER_HI], s_q.byte9[BYTE9_VER_LO]}
         == VERIFIED_MODE))) begin
      s_d.transp = 1'b1;
    end
    if (~activation_i) begin
      s_d.transp = 1'b0;
      s_d.rx_lock = 1'b0;
      s_d.tx_lock = 1'b0;
    end

    if (s_q.ctrl[CTRL_LOOP]) begin
      s_d.rx_bd = tx_bd_i;
      s_d.line_tx = (s_q.ctrl[CTRL_LOOP_TRANSP] & passing) ? tx_bd_i
                                                          : IDLE_ONES;
    end else begin
      s_d.rx_bd = line_rx_bd_i;
      s_d.line_tx = passing ? tx_bd_i : IDLE_ONES;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.tx_cnt <= CNT_PRE;
      s_q.rx_cnt <= CNT_PRE;
      s_q.ovl6 <= OVL6_RST;
      s_q.ovl8 <= OVL8_RST;
      s_q.nib2 <= NIB2_RST;
      s_q.byte9 <= BYTE9_RST;
      s_q.ctrl <= CTRL_RST;
      s_q.slot <= SLOT_RST;
      s_q.line_tx <= IDLE_ONES;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata_o = s_q.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & s_q.slverr;
  assign gci_frame_sync_o = s_q.fsc_out;
  assign gci_frame_sync_oe_o = gci_mode & gci_master;
  assign tx_superframe_marker_o = s_q.tx_mk;
  assign tx_superframe_marker_oe_o = native_mk & ~mk_input;
  assign rx_superframe_marker_o = s_q.rx_mk;
  assign tx_b1_window_o = s_q.tx_win;
  assign rx_b1_window_o = s_q.rx_win;
  assign line_tx_sf_start_o = s_q.line_sf;
  assign line_tx_bd_o = s_q.line_tx;
  assign rx_bd_o = s_q.rx_bd;
  assign transparent_o = s_q.transp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_IDX_RANGE: assert property (s_q.tx_idx < SF_FRAMES)
    else $error("tx frame index out of range");
  AST_RX_MK_GATE: assert property (rx_superframe_marker_o |->
    $past(s_q.ovl8[OVL8_MK_EN]) &&
    $past(s_q.rx_idx == 7'h00 || rx_next == 7'h00 || s_q.rx_pend))
    else $error("receive marker without enable or frame one");
  AST_MK_GCI_OFF: assert property (gci_mode |->
    !tx_superframe_marker_oe_o)
    else $error("marker driven in GCI format");
  AST_MK_DIR_LT: assert property (lt_mode && native_mk
    && !s_q.ovl8[OVL8_MK_OUT] |-> !tx_superframe_marker_oe_o)
    else $error("LT marker not an input");
  AST_IDLE_ONES: assert property (!s_q.transp && !s_q.ctrl[CTRL_LOOP]
    |=> line_tx_bd_o == IDLE_ONES)
    else $error("payload sent before transparency");
  AST_LOOP_IDLE: assert property (s_q.ctrl[CTRL_LOOP]
    && !s_q.ctrl[CTRL_LOOP_TRANSP] |=> line_tx_bd_o == IDLE_ONES)
    else $error("non-transparent loopback leaked data");
  AST_VERIFIED: assert property (activation_i && m4_act_i &&
    {s_q.byte9[BYTE9_VER_HI], s_q.byte9[BYTE9_VER_LO]} == VERIFIED_MODE
    |=> transparent_o)
    else $error("verified mode did not open data");
  AST_LOCK_HOLD: assert property (s_q.rx_lock && activation_i
    |=> s_q.rx_lock)
    else $error("alignment lock dropped within activation");
  AST_TURN_LEN: assert property ($rose(s_q.turn_run) |->
    s_q.turn_cnt == 17'(TURN_CNT - 1))
    else $error("turnaround count wrong");
  AST_FSC_SHORT: assert property ($rose(s_q.fsc_out)
    && s_q.gci_cnt == 10'h000 && rx_next == 7'h00 |->
    ##[1:40] !s_q.fsc_out)
    else $error("master sync not shortened");

  COV_TX_MK: cover property ($rose(tx_superframe_marker_o));
  COV_RX_MK: cover property ($rose(rx_superframe_marker_o));
  COV_TURN: cover property ($fell(s_q.turn_run));
  COV_TRANSP: cover property ($rose(transparent_o));

endmodule : tsa_superframe_align
`default_nettype wire

// ---- verif/tsa_host_model.sv ----
// Host side model: data clock, frame syncs and marker input.
`timescale 1ns/1ps
`default_nettype none
module tsa_host_model #(
  parameter int FR_DCK = 16
) (
  input wire logic long_i,
  input wire logic force_i,
  output logic port_data_clock_o,
  output logic tx_frame_sync_o,
  output logic rx_frame_sync_o,
  output logic tx_superframe_marker_o
);
  int cnt = 0;
  int frm = 0;
  logic lt = 1'b0;
  logic lr = 1'b0;
  // The port data clock is continuous, so it runs free between frames.
  initial begin
    port_data_clock_o = 1'b0;
    tx_superframe_marker_o = 1'b0;
    #3;
    forever #80 port_data_clock_o = ~port_data_clock_o;
  end
  // Syncs move on the falling edge and change width only at their own
  // frame boundary, so a width change never fakes a frame start.
  always @(negedge port_data_clock_o) begin
    cnt <= (cnt == FR_DCK - 1) ? 0 : cnt + 1;
    if (cnt == FR_DCK - 1) begin
      frm <= (frm == 95) ? 0 : frm + 1;
      lt <= long_i;
    end
    if (cnt == 7) begin
      lr <= long_i;
    end
  end
  assign tx_frame_sync_o = (cnt == 0) || (lt && cnt < 8);
  assign rx_frame_sync_o = (cnt == 8) || (lr && cnt > 8);
  always @(posedge port_data_clock_o) begin
    // Held over data clock 0, so the falling edge inside it catches it.
    tx_superframe_marker_o <= force_i && frm == 0 && cnt == 1;
  end
endmodule : tsa_host_model
`default_nettype wire

// ---- verif/tsa_superframe_align_tb.sv ----
// Self-checking bench of the superframe alignment block.
`timescale 1ns/1ps
`default_nettype none
module tsa_superframe_align_tb;
  import tsa_pkg::*;
  localparam int TC = 200;
  localparam int FR = 320;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic act = 1'b0;
  logic m4 = 1'b0;
  logic sfs = 1'b0;
  logic lng = 1'b0;
  logic tmd = 1'b0;
  logic [17:0] txd = 18'h2A5C3;
  logic [17:0] rxd = 18'h15A3C;
  logic [31:0] prd;
  logic [17:0] ltd;
  logic [17:0] rbd;
  logic dck, tfs, rfs, tmi, prdy, perr, gfoe, tmo, tmoe, rmo, tbw, rbw;
  logic lts, trn;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int txr = 0;
  tsa_superframe_align #(.TURN_CNT(TC)) DUT (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .port_data_clock_i(dck), .tx_frame_sync_i(tfs),
    .rx_frame_sync_i(rfs), .gci_frame_sync_i(tfs), .gci_frame_sync_o(),
    .gci_frame_sync_oe_o(gfoe), .tx_superframe_marker_i(tmi),
    .tx_superframe_marker_o(tmo), .tx_superframe_marker_oe_o(tmoe),
    .rx_superframe_marker_o(rmo), .tx_b1_window_o(tbw),
    .rx_b1_window_o(rbw), .activation_i(act), .m4_act_i(m4),
    .line_rx_sf_start_i(sfs), .line_tx_sf_start_o(lts), .tx_bd_i(txd),
    .line_tx_bd_o(ltd), .line_rx_bd_i(rxd), .rx_bd_o(rbd),
    .transparent_o(trn));
  tsa_host_model #(.FR_DCK(16)) host (.long_i(lng), .force_i(1'b0),
    .port_data_clock_o(dck), .tx_frame_sync_o(tfs),
    .rx_frame_sync_o(rfs), .tx_superframe_marker_o(tmi));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    tmd <= tmo;
    if (tmo === 1'b1 && tmd !== 1'b1) txr <= txr + 1;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("Mismatches %0d of %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e,
                       input string m);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_v
  task automatic chk_r(input int g, input int e, input int t,
                       input string m);
    comparisons++;
    if (g < e - t || g > e + t) begin
      bad_count++;
      $display("BAD %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask : chk_r
  function automatic logic pick(input int w);
    case (w)
      0: pick = tfs;
      1: pick = rfs;
      2: pick = tbw;
      3: pick = rbw;
      4: pick = rmo;
      5: pick = lts;
      default: pick = trn;
    endcase
  endfunction : pick
  task automatic wt(input int w, input logic v, output int n);
    n = 0;
    while (pick(w) !== v) begin
      @(posedge mclk_i);
      n++;
      if (n > 33000) begin
        bad_count++;
        $display("BAD %0t wait %0d timed out", $time, w);
        end_of_test();
      end
    end
  endtask : wt
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
      if (n > 50) begin
        bad_count++;
        $display("BAD %0t bus hang", $time);
        end_of_test();
      end
    end while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_regs();
    logic [7:0] ad[6] = '{ADDR_OVL6, ADDR_OVL8, ADDR_NIB2, ADDR_BYTE9,
                          ADDR_CTRL, ADDR_SLOT};
    logic [31:0] ex[6] = '{32'(OVL6_RST), 32'(OVL8_RST), 32'(NIB2_RST),
                           32'(BYTE9_RST), 32'(CTRL_RST), 32'(SLOT_RST)};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ad[i], 32'h0, r, e);
      chk_v(r, ex[i], "reset value");
    end
    wr(ADDR_CTRL, 32'h2A);
    apb(1'b0, ADDR_CTRL, 32'h0, r, e);
    chk_v(r, 32'h2A, "ctrl readback");
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk_v(32'(e), 32'h1, "unmapped error");
  endtask : sc_regs
  task automatic sc_oe();
    logic [7:0] o8[3] = '{8'h02, 8'h02, 8'h22};
    logic [7:0] ct[3] = '{8'h00, 8'h01, 8'h01};
    logic ex[3] = '{1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_OVL8, 32'(o8[i]));
      wr(ADDR_CTRL, 32'(ct[i]));
      @(posedge mclk_i);
      chk_v(32'(tmoe), 32'(ex[i]), "marker oe");
    end
    wr(ADDR_OVL6, 32'h08);
    wr(ADDR_CTRL, 32'h02);
    @(posedge mclk_i);
    chk_v(32'(gfoe), 32'h1, "gci sync oe");
    wr(ADDR_OVL8, 32'h00);
    wr(ADDR_CTRL, 32'h00);
  endtask : sc_oe
  task automatic sc_b1();
    logic [7:0] o6[4] = '{8'h00, 8'h80, 8'h80, 8'h00};
    logic [7:0] ct[4] = '{8'h00, 8'h00, 8'h08, 8'h08};
    int off[4] = '{0, 6, 6, 1};
    int base[2];
    int d;
    int n;
    wr(ADDR_SLOT, 32'h0303);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_OVL6, 32'(o6[i]));
      wr(ADDR_CTRL, 32'(ct[i]));
      for (int k = 0; k < 2; k++) begin
        wt(k, 1'b0, n);
        wt(k, 1'b1, n);
        wt(k + 2, 1'b1, d);
        if (i == 0) base[k] = d;
        chk_r(d, base[k] + 20 * off[i], 2, "b1 start");
      end
    end
    wt(3, 1'b0, d);
    chk_r(d, 160, 2, "b1 width");
    wr(ADDR_CTRL, 32'h00);
  endtask : sc_b1
  task automatic sc_idle();
    int n;
    act <= 1'b1;
    wr(ADDR_NIB2, 32'h1);
    repeat (4) @(posedge mclk_i);
    chk_v(32'(ltd), 32'(IDLE_ONES), "idle ones");
    m4 <= 1'b1;
    wt(6, 1'b1, n);
    repeat (2) @(posedge mclk_i);
    chk_v(32'(ltd), 32'(txd), "payload");
    wr(ADDR_CTRL, 32'h10);
    repeat (2) @(posedge mclk_i);
    chk_v(32'(rbd), 32'(txd), "loop data");
    chk_v(32'(ltd), 32'(IDLE_ONES), "loop idle");
    wr(ADDR_CTRL, 32'h30);
    repeat (2) @(posedge mclk_i);
    chk_v(32'(ltd), 32'(txd), "loop transparent");
    wr(ADDR_CTRL, 32'h00);
    act <= 1'b0;
    m4 <= 1'b0;
    wr(ADDR_NIB2, 32'h0);
    wr(ADDR_BYTE9, 32'h10);
    chk_v(32'(trn), 32'h0, "deactivated");
    chk_v(32'(rbd), 32'(rxd), "rx data");
    act <= 1'b1;
    m4 <= 1'b1;
    wt(6, 1'b1, n);
    repeat (2) @(posedge mclk_i);
    chk_v(32'(ltd), 32'(txd), "verified pass");
    wr(ADDR_BYTE9, 32'h00);
  endtask : sc_idle
  task automatic sc_turn();
    int n;
    int t0;
    act <= 1'b0;
    @(posedge mclk_i);
    act <= 1'b1;
    t0 = txr;
    sfs <= 1'b1;
    @(posedge mclk_i);
    sfs <= 1'b0;
    wt(5, 1'b1, n);
    chk_r(n, TC + FR / 2, FR / 2 + 10, "turnaround");
    repeat (FR) @(posedge mclk_i);
    chk_r(txr - t0, 0, 0, "marker disabled");
  endtask : sc_turn
  task automatic sc_mark();
    int n;
    int t0;
    int t1;
    wr(ADDR_OVL8, 32'h02);
    wt(4, 1'b1, n);
    t1 = cyc;
    t0 = txr;
    wt(4, 1'b0, n);
    chk_r(n, 20, 2, "short marker");
    lng <= 1'b1;
    wr(ADDR_CTRL, 32'h04);
    sfs <= 1'b1;
    @(posedge mclk_i);
    sfs <= 1'b0;
    wt(4, 1'b1, n);
    chk_r(cyc - t1, 96 * FR, 40, "superframe");
    chk_r(txr - t0, 1, 0, "tx marker count");
    wt(4, 1'b0, n);
    chk_r(n, 160, 2, "long marker");
  endtask : sc_mark
  initial begin
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    sc_regs();
    sc_oe();
    sc_b1();
    sc_idle();
    sc_turn();
    sc_mark();
    end_of_test();
  end
endmodule : tsa_superframe_align_tb
`default_nettype wire
